//--- verilog/adcc_consts.svh
// Register offsets, field positions and counts of the converter control block.
`ifndef ADCC_CONSTS_SVH
`define ADCC_CONSTS_SVH
`define ADCC_OFF_CTRL_FIRST  8'h00
`define ADCC_OFF_CTRL_SECOND 8'h04
`define ADCC_OFF_DELAY       8'h08
`define ADCC_OFF_RES_HIGH    8'h0C
`define ADCC_OFF_RES_LOW     8'h10
`define ADCC_OFF_IRQ_EN      8'h14
`define ADCC_OFF_IRQ_STAT    8'h18
`define ADCC_OFF_HI_BOUND    8'h1C
`define ADCC_OFF_LO_BOUND    8'h20
`define ADCC_B_FORMAT        4
`define ADCC_B_PWR_OFF       5
`define ADCC_B_BUSY          6
`define ADCC_B_SOFT_START    7
`define ADCC_B_SRC_SEL       3
`define ADCC_B_DLY_EN        4
`define ADCC_B_LO_CMP_EN     5
`define ADCC_B_HI_CMP_EN     6
`define ADCC_B_GLOBAL_EN     0
`define ADCC_B_CONV_EN       1
`define ADCC_B_MF_EN         2
`define ADCC_B_CONV_FLAG     0
`define ADCC_B_MF_FLAG       1
`define ADCC_B_BOUND_FLAG    2
`define ADCC_B_CMP_FLAG      3
`define ADCC_CONV_LAST       4'hF
`define ADCC_DIV_MAX_SEL     3'h6
`endif

//--- verilog/adcc_pkg.sv
// Types shared by the converter control block.
package adcc_pkg;
	// Sequencer states, Gray coded along idle, held in reset, converting.
	typedef enum logic [1:0]
	{
		ADCC_IDLE = 2'b00,
		ADCC_HOLD = 2'b01,
		ADCC_CONV = 2'b11
	} adcc_state_t;
endpackage

//--- verilog/adcc_clk_div.sv
// Converter clock divider producing one tick per converter clock period.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_consts.svh"
module adcc_clk_div
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       run,
	input  wire logic [2:0] div_sel,
	output logic            tick
);
	logic [5:0] cnt_r;   // Position inside the current converter clock period.
	logic [5:0] limit;   // Last count of a period for the chosen ratio.
	logic       tick_r;  // Registered period strobe.

	// Ratio is two to the power of the code; the undefined top code is held at the largest ratio.
	always_comb
	begin
		if (div_sel > `ADCC_DIV_MAX_SEL)
			limit = 6'h3F;
		else
			limit = 6'((7'h01 << div_sel) - 7'h01);
	end

	// The counter restarts whenever the sequencer is not converting, so every conversion starts on a whole period.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_r  <= 6'h00;
			tick_r <= 1'b0;
		end
		else if (!run)
		begin
			cnt_r  <= 6'h00;
			tick_r <= 1'b0;
		end
		else
		begin
			tick_r <= (cnt_r == limit);
			cnt_r  <= (cnt_r == limit) ? 6'h00 : cnt_r + 6'h01;
		end
	end

	assign tick = tick_r;

	chk_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
		tick |-> $past(cnt_r) == $past(limit)) else $error("divider tick off its period");
endmodule
`default_nettype wire

//--- verilog/adcc_trig_delay.sv
// Delay of a PWM trigger by a programmed number of system clocks.
`timescale 1ns/1ps
`default_nettype none
module adcc_trig_delay
#(
	parameter int DW = 8
)
(
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          trig,
	input  wire logic          delay_en,
	input  wire logic [DW-1:0] delay_count,
	input  wire logic          abort,
	output logic               start
);
	logic [DW-1:0] cnt_r;     // System clocks still to wait.
	logic          pending_r; // A delayed trigger is waiting.
	logic          start_r;   // Registered start strobe.

	// A zero count or a cleared enable passes the trigger straight on; the wait is count clocks otherwise.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_r     <= '0;
			pending_r <= 1'b0;
			start_r   <= 1'b0;
		end
		else if (abort)
		begin
			pending_r <= 1'b0;
			start_r   <= 1'b0;
		end
		else if (pending_r)
		begin
			start_r   <= (cnt_r == '0);
			pending_r <= (cnt_r != '0);
			cnt_r     <= (cnt_r == '0) ? cnt_r : cnt_r - 1'b1;
		end
		else
		begin
			start_r   <= trig && !(delay_en && delay_count != '0);
			pending_r <= trig && delay_en && delay_count != '0;
			cnt_r     <= delay_count - 1'b1;
		end
	end

	assign start = start_r;

	chk_delay_release: assert property (@(posedge pclk) disable iff (!presetn)
		!abort && !pending_r && trig && delay_en && delay_count == 8'h02 |=> !start ##1 !start ##1 start)
		else $error("delayed start not after the programmed count");
endmodule
`default_nettype wire

//--- verilog/adcc_top.sv
// APB register file and sequencer of the converter control block.
// Notes on behaviour
// - converter clock divided down from system clock.
// - codes 0 to 6 divide by powers.
// - converter runs only while power-off is clear.
// - power-off set switches converter fully off.
// - input select field routes converter input.
// - source bit picks soft start or PWM.
// - format bit arranges result across bytes.
// - interrupt needs global, converter, multi-function enables.
// - start bit raised then cleared starts conversion.
// - start bit left high holds reset, busy.
// - optional delay between PWM trigger and start.
// - delay equals count times system clock.
// - busy high during conversion, low after.
// - result readable in high and low registers.
// - completion raises converter interrupt request.
// - conversion lasts sixteen converter clock periods.
// - conversion runs alone, processor keeps working.
// - twelve-bit unsigned result, full scale all ones.
// - boundary and comparator interrupts available.
// - result compared against enabled high/low bounds.
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_consts.svh"
module adcc_top
#(
	parameter int AW = 8,
	parameter int DW = 8
)
(
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [AW-1:0] paddr,
	input  wire logic [31:0]   pwdata,
	output logic [31:0]        prdata,
	output logic               pready,
	output logic               pslverr,
	input  wire logic          pwm_trigger,
	input  wire logic [11:0]   conv_sample_data,
	input  wire logic          current_comparator_event,
	output logic               conv_power_on,
	output logic               conv_reset,
	output logic               conv_clk_tick,
	output logic [3:0]         conv_input_sel,
	output logic               conv_irq,
	output logic               boundary_limit_irq,
	output logic               current_comparator_irq
);
	// Software-visible control fields.
	logic [3:0]    input_sel_r;         // Channel routed to the converter.
	logic          result_format_sel_r; // Result arrangement across the two bytes.
	logic          conv_power_off_r;    // Converter switched off when high.
	logic          soft_start_bit_r;    // Software start bit.
	logic [2:0]    div_sel_r;           // Converter clock ratio code.
	logic          trigger_source_sel_r; // Low picks software, high picks PWM.
	logic          delay_start_enable_r; // Delayed PWM start enable.
	logic          lo_cmp_en_r;         // Low boundary comparison enable.
	logic          hi_cmp_en_r;         // High boundary comparison enable.
	logic [DW-1:0] trigger_delay_count_r; // Delay in system clocks.
	logic [2:0]    irq_en_r;            // Global, converter, multi-function enables.
	logic [3:0]    irq_flag_r;          // Converter, multi-function, boundary, comparator flags.
	logic [11:0]   hi_bound_r;          // High limit, right justified.
	logic [11:0]   lo_bound_r;          // Low limit, right justified.
	logic [7:0]    result_high_r;       // Upper result byte.
	logic [7:0]    result_low_r;        // Lower result byte.
	logic [31:0]   prdata_r;            // Read data captured in the setup cycle.
	logic          addr_err_r;          // Unmapped address seen in the setup cycle.

	// Sequencer.
	adcc_pkg::adcc_state_t state_r;     // Present sequencer state.
	adcc_pkg::adcc_state_t state_nxt;   // Next sequencer state.
	logic [3:0]    period_cnt_r;        // Converter clock periods already spent.
	logic          tick;                // One strobe per converter clock period.
	logic          pwm_start;           // PWM trigger after the optional delay.
	logic          done;                // Last period of a conversion ends now.
	logic          wr_en;               // APB write takes effect this edge.
	logic          setup;               // APB setup cycle.
	logic [3:0]    flag_clr;            // Write-one-to-clear mask.
	logic [3:0]    flag_set;            // Hardware events this cycle.

	assign setup   = psel && !penable;
	assign wr_en   = psel && penable && pwrite;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && addr_err_r;
	assign prdata  = prdata_r;

	// Divider runs only while a conversion is under way so its periods line up with the start.
	adcc_clk_div u_div
	(
		.pclk    (pclk),
		.presetn (presetn),
		.run     (state_r == adcc_pkg::ADCC_CONV),
		.div_sel (div_sel_r),
		.tick    (tick)
	);

	// PWM trigger path with its programmable wait; only used while the PWM source is chosen.
	adcc_trig_delay #(.DW(DW)) u_dly
	(
		.pclk        (pclk),
		.presetn     (presetn),
		.trig        (pwm_trigger && trigger_source_sel_r),
		.delay_en    (delay_start_enable_r),
		.delay_count (trigger_delay_count_r),
		.abort       (conv_power_off_r || !trigger_source_sel_r),
		.start       (pwm_start)
	);

	assign done = (state_r == adcc_pkg::ADCC_CONV) && tick && (period_cnt_r == `ADCC_CONV_LAST);

	// Next state; a PWM trigger that arrives while converting is ignored, a raised start bit goes back to hold.
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			adcc_pkg::ADCC_IDLE:
			begin
				if (!trigger_source_sel_r && soft_start_bit_r)
					state_nxt = adcc_pkg::ADCC_HOLD;
				else if (trigger_source_sel_r && pwm_start)
					state_nxt = adcc_pkg::ADCC_CONV;
			end
			adcc_pkg::ADCC_HOLD:
			begin
				if (trigger_source_sel_r)
					state_nxt = adcc_pkg::ADCC_IDLE;
				else if (!soft_start_bit_r)
					state_nxt = adcc_pkg::ADCC_CONV;
			end
			adcc_pkg::ADCC_CONV:
			begin
				if (!trigger_source_sel_r && soft_start_bit_r)
					state_nxt = adcc_pkg::ADCC_HOLD;
				else if (done)
					state_nxt = adcc_pkg::ADCC_IDLE;
			end
			default:
				state_nxt = adcc_pkg::ADCC_IDLE;
		endcase
		if (conv_power_off_r)
			state_nxt = adcc_pkg::ADCC_IDLE;
	end

	// Sequencer state; the processor only starts it, the rest runs here on its own.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_r <= adcc_pkg::ADCC_IDLE;
		else
			state_r <= state_nxt;
	end

	// Period counter restarts on every fresh entry to the converting state.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			period_cnt_r <= 4'h0;
		else if (state_r != adcc_pkg::ADCC_CONV)
			period_cnt_r <= 4'h0;
		else if (tick)
			period_cnt_r <= period_cnt_r + 4'h1;
	end

	// Analog side controls.
	assign conv_power_on  = !conv_power_off_r;
	assign conv_reset     = (state_r == adcc_pkg::ADCC_HOLD);
	assign conv_clk_tick  = tick;
	assign conv_input_sel = input_sel_r;

	// Result bytes change only at completion and always as a pair, so a read never mixes two conversions.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			result_high_r <= 8'h00;
			result_low_r  <= 8'h00;
		end
		else if (done)
		begin
			if (result_format_sel_r)
			begin
				result_high_r <= {4'h0, conv_sample_data[11:8]};
				result_low_r  <= conv_sample_data[7:0];
			end
			else
			begin
				result_high_r <= conv_sample_data[11:4];
				result_low_r  <= {conv_sample_data[3:0], 4'h0};
			end
		end
	end

	// Hardware events; a full-scale code is plain unsigned and needs no special case.
	assign flag_set[`ADCC_B_CONV_FLAG]  = done;
	assign flag_set[`ADCC_B_MF_FLAG]    = done && irq_en_r[`ADCC_B_CONV_EN];
	assign flag_set[`ADCC_B_BOUND_FLAG] = done && ((hi_cmp_en_r && conv_sample_data > hi_bound_r) ||
		(lo_cmp_en_r && conv_sample_data < lo_bound_r));
	assign flag_set[`ADCC_B_CMP_FLAG]   = current_comparator_event;
	assign flag_clr = (wr_en && paddr == `ADCC_OFF_IRQ_STAT) ? pwdata[3:0] : 4'h0;

	// Flags are sticky, cleared by writing ones, and a new event in the clearing cycle wins.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_flag_r <= 4'h0;
		else
			irq_flag_r <= flag_set | (irq_flag_r & ~flag_clr);
	end

	assign conv_irq = irq_en_r[`ADCC_B_GLOBAL_EN] && irq_en_r[`ADCC_B_MF_EN] &&
		irq_flag_r[`ADCC_B_MF_FLAG];
	assign boundary_limit_irq     = irq_flag_r[`ADCC_B_BOUND_FLAG];
	assign current_comparator_irq = irq_flag_r[`ADCC_B_CMP_FLAG];

	// Control register writes; reset leaves the converter powered off.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			input_sel_r           <= 4'h0;
			result_format_sel_r   <= 1'b0;
			conv_power_off_r      <= 1'b1;
			soft_start_bit_r      <= 1'b0;
			div_sel_r             <= 3'h0;
			trigger_source_sel_r  <= 1'b0;
			delay_start_enable_r  <= 1'b0;
			lo_cmp_en_r           <= 1'b0;
			hi_cmp_en_r           <= 1'b0;
			trigger_delay_count_r <= '0;
			irq_en_r              <= 3'h0;
			hi_bound_r            <= 12'h000;
			lo_bound_r            <= 12'h000;
		end
		else if (wr_en)
		begin
			case (paddr)
				`ADCC_OFF_CTRL_FIRST:
				begin
					input_sel_r         <= pwdata[3:0];
					result_format_sel_r <= pwdata[`ADCC_B_FORMAT];
					conv_power_off_r    <= pwdata[`ADCC_B_PWR_OFF];
					soft_start_bit_r    <= pwdata[`ADCC_B_SOFT_START];
				end
				`ADCC_OFF_CTRL_SECOND:
				begin
					div_sel_r            <= pwdata[2:0];
					trigger_source_sel_r <= pwdata[`ADCC_B_SRC_SEL];
					delay_start_enable_r <= pwdata[`ADCC_B_DLY_EN];
					lo_cmp_en_r          <= pwdata[`ADCC_B_LO_CMP_EN];
					hi_cmp_en_r          <= pwdata[`ADCC_B_HI_CMP_EN];
				end
				`ADCC_OFF_DELAY:    trigger_delay_count_r <= pwdata[DW-1:0];
				`ADCC_OFF_IRQ_EN:   irq_en_r <= pwdata[2:0];
				`ADCC_OFF_HI_BOUND: hi_bound_r <= pwdata[11:0];
				`ADCC_OFF_LO_BOUND: lo_bound_r <= pwdata[11:0];
				default:            ;
			endcase
		end
	end

	// Read data is captured in the setup cycle, so the slave answers with no wait state.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_r   <= 32'h0000_0000;
			addr_err_r <= 1'b0;
		end
		else if (setup)
		begin
			addr_err_r <= 1'b0;
			case (paddr)
				`ADCC_OFF_CTRL_FIRST:  prdata_r <= {24'h000000, soft_start_bit_r,
					state_r != adcc_pkg::ADCC_IDLE, conv_power_off_r, result_format_sel_r, input_sel_r};
				`ADCC_OFF_CTRL_SECOND: prdata_r <= {25'h0000000, hi_cmp_en_r, lo_cmp_en_r,
					delay_start_enable_r, trigger_source_sel_r, div_sel_r};
				`ADCC_OFF_DELAY:       prdata_r <= {24'h000000, trigger_delay_count_r};
				`ADCC_OFF_RES_HIGH:    prdata_r <= {24'h000000, result_high_r};
				`ADCC_OFF_RES_LOW:     prdata_r <= {24'h000000, result_low_r};
				`ADCC_OFF_IRQ_EN:      prdata_r <= {29'h00000000, irq_en_r};
				`ADCC_OFF_IRQ_STAT:    prdata_r <= {28'h0000000, irq_flag_r};
				`ADCC_OFF_HI_BOUND:    prdata_r <= {20'h00000, hi_bound_r};
				`ADCC_OFF_LO_BOUND:    prdata_r <= {20'h00000, lo_bound_r};
				default:
				begin
					prdata_r   <= 32'h0000_0000;
					addr_err_r <= 1'b1;
				end
			endcase
		end
	end

	// Checks beside the logic.
	// Power is judged in the same cycle and the state one cycle later, so clearing the bit may follow at once.
	chk_power_off_idle: assert property (@(posedge pclk) disable iff (!presetn)
		conv_power_off_r |-> !conv_power_on ##1 state_r == adcc_pkg::ADCC_IDLE)
		else $error("converter active while powered off");
	chk_hold_reset: assert property (@(posedge pclk) disable iff (!presetn)
		soft_start_bit_r && !trigger_source_sel_r && !conv_power_off_r ##1 soft_start_bit_r
		|-> conv_reset && state_r != adcc_pkg::ADCC_IDLE) else $error("start bit held high without reset");
	chk_soft_start: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == adcc_pkg::ADCC_HOLD && !soft_start_bit_r && !trigger_source_sel_r && !conv_power_off_r
		|=> state_r == adcc_pkg::ADCC_CONV) else $error("start bit pulse did not start");
	chk_busy_done: assert property (@(posedge pclk) disable iff (!presetn)
		done && !conv_power_off_r && !soft_start_bit_r |=> state_r == adcc_pkg::ADCC_IDLE)
		else $error("busy did not fall at completion");
	chk_conv_length: assert property (@(posedge pclk) disable iff (!presetn)
		done |-> $past(period_cnt_r) == 4'hE || $past(period_cnt_r) == 4'hF)
		else $error("conversion not sixteen periods");
	chk_result_pair: assert property (@(posedge pclk) disable iff (!presetn)
		done && !result_format_sel_r |=> result_high_r == $past(conv_sample_data[11:4]) &&
		result_low_r == {$past(conv_sample_data[3:0]), 4'h0}) else $error("result bytes wrong");
	chk_result_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!done |=> $stable(result_high_r) && $stable(result_low_r)) else $error("result changed early");
	chk_flag_on_done: assert property (@(posedge pclk) disable iff (!presetn)
		done |=> irq_flag_r[`ADCC_B_CONV_FLAG]) else $error("completion flag not raised");
	chk_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		irq_flag_r[`ADCC_B_CONV_FLAG] && !flag_clr[`ADCC_B_CONV_FLAG] |=> irq_flag_r[`ADCC_B_CONV_FLAG])
		else $error("completion flag lost");
	chk_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
		conv_irq |-> irq_en_r[`ADCC_B_GLOBAL_EN] && irq_en_r[`ADCC_B_MF_EN])
		else $error("interrupt passed a cleared enable");
	cov_soft_conv: cover property (@(posedge pclk) disable iff (!presetn)
		state_r == adcc_pkg::ADCC_HOLD ##1 state_r == adcc_pkg::ADCC_CONV);
	cov_pwm_done: cover property (@(posedge pclk) disable iff (!presetn) done && trigger_source_sel_r);
	cov_bound_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(boundary_limit_irq));
	cov_conv_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(conv_irq));
endmodule
`default_nettype wire

//--- tb/adc_conversion_control_tb.sv
// Self-checking testbench of the converter control block, driven over APB.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_consts.svh"
module adc_conversion_control_tb;
	logic        pclk;          // System clock, 8 ns period.
	logic        presetn;       // Active low reset.
	logic        psel;          // APB select.
	logic        penable;       // APB access phase.
	logic        pwrite;        // APB direction.
	logic [7:0]  paddr;         // APB byte address.
	logic [31:0] pwdata;        // APB write data.
	logic [31:0] prdata;        // APB read data.
	logic        pready;        // APB ready.
	logic        pslverr;       // APB error.
	logic        pwm_trigger;   // PWM interrupt event.
	logic [11:0] sample;        // Value the converter hands back.
	logic        cmp_event;     // Comparator event pulse.
	logic        conv_power_on; // Converter power.
	logic        conv_reset;    // Converter held in reset.
	logic [3:0]  conv_input_sel;// Routed input.
	logic        conv_irq;      // Conversion interrupt.
	logic        bound_irq;     // Boundary interrupt.
	logic        cmp_irq;       // Comparator interrupt.
	int          fail_count;    // Mismatches seen.
	int          checks_done;   // Comparisons made.
	int          cycle_count;   // Free running cycle counter.
	logic [31:0] rd;            // Last read data.
	logic        err;           // Last error response.
	int          t0;            // Start time of a measured conversion.
	int          n0;            // Latency without delay.
	logic        conv_tick;     // Converter clock period strobe.
	int          tick_count;    // Converter clock periods seen.
	int          k0;            // Periods seen at the start of a conversion.
	adcc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pwm_trigger(pwm_trigger), .conv_sample_data(sample), .current_comparator_event(cmp_event),
		.conv_power_on(conv_power_on), .conv_reset(conv_reset), .conv_clk_tick(conv_tick),
		.conv_input_sel(conv_input_sel), .conv_irq(conv_irq), .boundary_limit_irq(bound_irq),
		.current_comparator_irq(cmp_irq));
	// Clock generator.
	always #4 pclk = ~pclk;
	// Cycle counter and hang guard; the whole run needs well under this ceiling.
	always @(posedge pclk)
	begin
		cycle_count <= cycle_count + 1;
		// Every converter clock period is counted so a conversion can be measured in periods.
		if (conv_tick)
			tick_count <= tick_count + 1;
		if (cycle_count == 30000)
		begin
			fail_count++;
			stop_test();
		end
	end
	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("Checks done %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Compares one value and reports a mismatch at once.
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			$display("Error %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask
	// One APB transfer; the request is held until pready is sampled high.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Waits for the conversion interrupt, sampling after each edge has settled.
	task automatic wait_irq();
		do begin @(posedge pclk); #1; end while (conv_irq !== 1'b1);
	endtask
	// Software start: raise the start bit, check the held state, clear it again.
	task automatic soft_start(input logic [7:0] cfg);
		apb(1'b1, `ADCC_OFF_CTRL_FIRST, {24'h0, cfg | 8'h80});
		apb(1'b0, `ADCC_OFF_CTRL_FIRST, 32'h0);
		chk("busy held", 32'h1, rd[`ADCC_B_BUSY]);
		chk("conv reset", 32'h1, conv_reset);
		apb(1'b1, `ADCC_OFF_CTRL_FIRST, {24'h0, cfg});
		t0 = cycle_count;
		k0 = tick_count;
		apb(1'b0, `ADCC_OFF_CTRL_FIRST, 32'h0);
		chk("busy running", 32'h1, rd[`ADCC_B_BUSY]);
	endtask
	// Pulses the PWM trigger for one cycle.
	task automatic pwm_pulse();
		@(posedge pclk);
		pwm_trigger <= 1'b1;
		t0 = cycle_count;
		@(posedge pclk);
		pwm_trigger <= 1'b0;
	endtask
	// Main sequence of tests.
	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pwm_trigger = 1'b0;
		sample = 12'hABC;
		cmp_event = 1'b0;
		fail_count = 0;
		checks_done = 0;
		cycle_count = 0;
		tick_count = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `ADCC_OFF_CTRL_FIRST, 32'h0);
		chk("first control reset", 32'h20, rd);
		chk("power at reset", 32'h0, conv_power_on);
		apb(1'b0, 8'h24, 32'h0);
		chk("unmapped error", 32'h1, err);
		chk("unmapped data", 32'h0, rd);
		$display("Test reset and map finished");
		apb(1'b1, `ADCC_OFF_IRQ_EN, 32'h7);
		// Every defined divider code, latency of sixteen converter clocks.
		for (int c = 0; c <= 6; c++)
		begin
			apb(1'b1, `ADCC_OFF_CTRL_SECOND, c);
			apb(1'b1, `ADCC_OFF_IRQ_STAT, 32'hF);
			soft_start(8'h05);
			wait_irq();
			chk("tick count", 32'd16, tick_count - k0);
			checks_done++;
			if ((cycle_count - t0) < (16 << c) || (cycle_count - t0) > (16 << c) + 6)
			begin
				$display("Error latency code %0d expected %0d seen %0d", c, 16 << c, cycle_count - t0);
				fail_count++;
			end
		end
		chk("power on", 32'h1, conv_power_on);
		chk("input select", 32'h5, conv_input_sel);
		apb(1'b0, `ADCC_OFF_CTRL_FIRST, 32'h0);
		chk("busy done", 32'h0, rd[`ADCC_B_BUSY]);
		sample <= 12'h123;
		apb(1'b0, `ADCC_OFF_RES_HIGH, 32'h0);
		chk("result high", 32'hAB, rd);
		apb(1'b0, `ADCC_OFF_RES_LOW, 32'h0);
		chk("result low", 32'hC0, rd);
		apb(1'b0, `ADCC_OFF_IRQ_STAT, 32'h0);
		chk("conv flag", 32'h1, rd[`ADCC_B_CONV_FLAG]);
		apb(1'b1, `ADCC_OFF_IRQ_STAT, 32'hF);
		#1;
		chk("irq cleared", 32'h0, conv_irq);
		$display("Test dividers finished");
		// Right justified format with high boundary compare.
		sample <= 12'h9A5;
		apb(1'b1, `ADCC_OFF_HI_BOUND, 32'h800);
		apb(1'b1, `ADCC_OFF_CTRL_SECOND, 32'h40);
		apb(1'b1, `ADCC_OFF_IRQ_EN, 32'h6);
		soft_start(8'h15);
		repeat (40) @(posedge pclk);
		#1;
		chk("irq gated", 32'h0, conv_irq);
		chk("boundary irq", 32'h1, bound_irq);
		apb(1'b1, `ADCC_OFF_IRQ_EN, 32'h7);
		#1;
		chk("irq enabled", 32'h1, conv_irq);
		apb(1'b0, `ADCC_OFF_RES_HIGH, 32'h0);
		chk("right high", 32'h09, rd);
		apb(1'b0, `ADCC_OFF_RES_LOW, 32'h0);
		chk("right low", 32'hA5, rd);
		$display("Test format and interrupt finished");
		// PWM trigger ignored under software source, then used with and without delay.
		apb(1'b1, `ADCC_OFF_IRQ_STAT, 32'hF);
		pwm_pulse();
		apb(1'b0, `ADCC_OFF_CTRL_FIRST, 32'h0);
		chk("pwm ignored", 32'h0, rd[`ADCC_B_BUSY]);
		apb(1'b1, `ADCC_OFF_CTRL_SECOND, 32'h08);
		pwm_pulse();
		wait_irq();
		n0 = cycle_count - t0;
		chk("pwm start", 32'h1, (n0 >= 17 && n0 <= 22));
		apb(1'b1, `ADCC_OFF_IRQ_STAT, 32'hF);
		apb(1'b1, `ADCC_OFF_DELAY, 32'd2);
		apb(1'b1, `ADCC_OFF_LO_BOUND, 32'hA00);
		apb(1'b1, `ADCC_OFF_CTRL_SECOND, 32'h38);
		pwm_pulse();
		wait_irq();
		chk("pwm delay", 32'd2, cycle_count - t0 - n0);
		chk("low bound irq", 32'h1, bound_irq);
		$display("Test trigger finished");
		@(posedge pclk);
		cmp_event <= 1'b1;
		@(posedge pclk);
		cmp_event <= 1'b0;
		repeat (2) @(posedge pclk);
		#1;
		chk("comparator irq", 32'h1, cmp_irq);
		$display("Test comparator finished");
		stop_test();
	end
endmodule
`default_nettype wire
